// ==== common/pfbm_map.vh ====
// Purpose: timing counts and command constants for the flash bus host
// Assumes: 125 MHz clock, 8 ns period
// Notes:   times are in ns; cycle counts derive from them
`ifndef PFBM_MAP_VH
`define PFBM_MAP_VH

`define PFBM_CLK_NS            8
// ----------------------------------------
// device timing figures, ns
// ----------------------------------------
`define PFBM_ADDR_ACCESS_NS    70
`define PFBM_SELECT_ACCESS_NS  70
`define PFBM_WRITE_PULSE_NS    35
`define PFBM_WRITE_HOLD_NS     30
`define PFBM_CLEAR_PULSE_NS    500
`define PFBM_CLEAR_READY_NS    20000
`define PFBM_CLEAR_TO_READ_NS  50
// least times round up
`define PFBM_CYC(ns)           (((ns) + `PFBM_CLK_NS - 1) / `PFBM_CLK_NS)
// ----------------------------------------
// command codes and unlock addresses
// ----------------------------------------
`define PFBM_UNLOCK_ADDR1      20'h00555
`define PFBM_UNLOCK_ADDR2      20'h002AA
`define PFBM_UNLOCK_DATA1      16'h00AA
`define PFBM_UNLOCK_DATA2      16'h0055
`define PFBM_CMD_PROGRAM       16'h00A0
`define PFBM_CMD_ERASE         16'h0080
`define PFBM_CMD_CHIP_ERASE    16'h0010
`define PFBM_CMD_SECTOR_ERASE  16'h0030
`define PFBM_CMD_IDENT         16'h0090
`define PFBM_CMD_BYPASS        16'h0020
`define PFBM_CMD_RESET         16'h00F0
// ----------------------------------------
// request operation codes
// ----------------------------------------
`define PFBM_OP_READ           3'h0
`define PFBM_OP_WRITE          3'h1
`define PFBM_OP_PROGRAM        3'h2
`define PFBM_OP_ERASE_SECTOR   3'h3
`define PFBM_OP_ERASE_CHIP     3'h4
`define PFBM_OP_IDENT          3'h5
`define PFBM_OP_BYPASS_ENTER   3'h6
`define PFBM_OP_HW_RESET       3'h7
`endif

// ==== hdl/pfbm_seq_rom.v ====
// Purpose: command sequence table, registered read data
// Assumes: index = {op, step}
// Notes:   holds address, data and last-step mark per bus cycle
`timescale 1ns/1ps
`include "pfbm_map.vh"

module pfbm_seq_rom
(
	// clock and reset
	input  wire        clk_i,
	input  wire        reset_n_i,
	// lookup
	input  wire [2:0]  op_i,
	input  wire [2:0]  step_i,
	input  wire        bypass_i,
	input  wire [19:0] user_addr_i,
	input  wire [15:0] user_data_i,
	output reg  [19:0] addr_o,
	output reg  [15:0] data_o,
	output reg         last_o
);
	reg [19:0] a;
	reg [15:0] d;
	reg        l;

	always @*
	begin
		a = user_addr_i;
		d = user_data_i;
		l = 1'b1;
		case ({op_i, step_i})
			// bypass program takes two cycles, standard four
			{`PFBM_OP_PROGRAM, 3'h0}:
			begin
				a = `PFBM_UNLOCK_ADDR1;
				d = bypass_i ? `PFBM_CMD_PROGRAM : `PFBM_UNLOCK_DATA1;
				l = 1'b0;
			end
			{`PFBM_OP_PROGRAM, 3'h1}:
			begin
				a = bypass_i ? user_addr_i : `PFBM_UNLOCK_ADDR2;
				d = bypass_i ? user_data_i : `PFBM_UNLOCK_DATA2;
				l = bypass_i;
			end
			{`PFBM_OP_PROGRAM, 3'h2}:
			begin
				a = `PFBM_UNLOCK_ADDR1;
				d = `PFBM_CMD_PROGRAM;
				l = 1'b0;
			end
			{`PFBM_OP_ERASE_SECTOR, 3'h0}, {`PFBM_OP_ERASE_CHIP, 3'h0},
			{`PFBM_OP_IDENT, 3'h0}, {`PFBM_OP_BYPASS_ENTER, 3'h0},
			{`PFBM_OP_ERASE_SECTOR, 3'h3}, {`PFBM_OP_ERASE_CHIP, 3'h3}:
			begin
				a = `PFBM_UNLOCK_ADDR1;
				d = `PFBM_UNLOCK_DATA1;
				l = 1'b0;
			end
			{`PFBM_OP_ERASE_SECTOR, 3'h1}, {`PFBM_OP_ERASE_CHIP, 3'h1},
			{`PFBM_OP_IDENT, 3'h1}, {`PFBM_OP_BYPASS_ENTER, 3'h1},
			{`PFBM_OP_ERASE_SECTOR, 3'h4}, {`PFBM_OP_ERASE_CHIP, 3'h4}:
			begin
				a = `PFBM_UNLOCK_ADDR2;
				d = `PFBM_UNLOCK_DATA2;
				l = 1'b0;
			end
			{`PFBM_OP_ERASE_SECTOR, 3'h2}, {`PFBM_OP_ERASE_CHIP, 3'h2}:
			begin
				a = `PFBM_UNLOCK_ADDR1;
				d = `PFBM_CMD_ERASE;
				l = 1'b0;
			end
			{`PFBM_OP_ERASE_CHIP, 3'h5}:
			begin
				a = `PFBM_UNLOCK_ADDR1;
				d = `PFBM_CMD_CHIP_ERASE;
			end
			// sector address from A19..A12, last cycle of the sequence
			{`PFBM_OP_ERASE_SECTOR, 3'h5}:
				d = `PFBM_CMD_SECTOR_ERASE;
			{`PFBM_OP_IDENT, 3'h2}:
			begin
				a = `PFBM_UNLOCK_ADDR1;
				d = `PFBM_CMD_IDENT;
			end
			{`PFBM_OP_BYPASS_ENTER, 3'h2}:
			begin
				a = `PFBM_UNLOCK_ADDR1;
				d = `PFBM_CMD_BYPASS;
			end
			default:
				l = 1'b1;
		endcase
	end

	always @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			addr_o <= 20'h00000;
			data_o <= 16'h0000;
			last_o <= 1'b0;
		end
		else
		begin
			addr_o <= a;
			data_o <= d;
			last_o <= l;
		end
	end
endmodule // pfbm_seq_rom

// ==== hdl/pfbm_host.v ====
// Purpose: host controller driving a parallel boot-sector NOR flash
// Assumes: flash pins synchronous to clk_i; one request at a time
// Notes:   timing figures in pfbm_map.vh
`timescale 1ns/1ps
`include "pfbm_map.vh"

module pfbm_host
#(
	parameter CLEAR_READY_CYC = `PFBM_CYC(`PFBM_CLEAR_READY_NS)
)
(
	// clock and reset
	input  wire        clk_i,
	input  wire        reset_n_i,
	// request side
	input  wire        req_valid_i,
	input  wire [2:0]  req_op_i,
	input  wire [20:0] req_addr_i,
	input  wire [15:0] req_data_i,
	input  wire        byte_mode_i,
	output reg         req_ready_o,
	output reg         rsp_valid_o,
	output reg  [15:0] rsp_data_o,
	output reg         reissue_o,
	// flash pins
	output reg  [19:0] flash_addr_o,
	output reg  [15:0] flash_dq_o,
	output reg  [15:0] flash_dq_oe_n_o,
	input  wire [15:0] flash_dq_i,
	output reg         flash_sel_n_o,
	output reg         flash_gate_n_o,
	output reg         flash_wstrobe_n_o,
	output reg         flash_width_n_o,
	output reg         flash_clear_n_o,
	input  wire        op_done_flag_n
);
	// ----------------------------------------
	// timing counts
	// ----------------------------------------
	localparam [15:0] ACC_CYC   = `PFBM_CYC(`PFBM_ADDR_ACCESS_NS);
	localparam [15:0] SEL_CYC   = `PFBM_CYC(`PFBM_SELECT_ACCESS_NS);
	localparam [15:0] WP_CYC    = `PFBM_CYC(`PFBM_WRITE_PULSE_NS);
	localparam [15:0] WH_CYC    = `PFBM_CYC(`PFBM_WRITE_HOLD_NS);
	localparam [15:0] CP_CYC    = `PFBM_CYC(`PFBM_CLEAR_PULSE_NS);
	localparam [15:0] CRD_CYC   = CLEAR_READY_CYC;
	localparam [15:0] RH_CYC    = `PFBM_CYC(`PFBM_CLEAR_TO_READ_NS);

	localparam [2:0] S_IDLE   = 3'h0;
	localparam [2:0] S_LOOK   = 3'h1;
	localparam [2:0] S_WLOW   = 3'h2;
	localparam [2:0] S_WHIGH  = 3'h3;
	localparam [2:0] S_READ   = 3'h4;
	localparam [2:0] S_CLRLOW = 3'h5;
	localparam [2:0] S_CLRWT  = 3'h6;
	localparam [2:0] S_RECOV  = 3'h7;

	reg  [2:0]  state;
	reg  [2:0]  op;
	reg  [2:0]  step;
	reg  [15:0] cnt;
	reg  [20:0] uaddr;
	reg  [15:0] udata;
	reg         bypass;
	reg         busy_seen;
	reg         selected;
	reg         seq_end;
	wire [19:0] rom_addr;
	wire [15:0] rom_data;
	wire        rom_last;

	pfbm_seq_rom u_rom
	(
		.clk_i       (clk_i),
		.reset_n_i   (reset_n_i),
		.op_i        (op),
		.step_i      (step),
		.bypass_i    (bypass),
		.user_addr_i (uaddr[20:1]),
		.user_data_i (udata),
		.addr_o      (rom_addr),
		.data_o      (rom_data),
		.last_o      (rom_last)
	);

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			state             <= S_IDLE;
			op                <= 3'h0;
			step              <= 3'h0;
			cnt               <= 16'h0000;
			uaddr             <= 21'h000000;
			udata             <= 16'h0000;
			bypass            <= 1'b0;
			busy_seen         <= 1'b0;
			selected          <= 1'b0;
			seq_end           <= 1'b0;
			req_ready_o       <= 1'b0;
			rsp_valid_o       <= 1'b0;
			rsp_data_o        <= 16'h0000;
			reissue_o         <= 1'b0;
			flash_addr_o      <= 20'h00000;
			flash_dq_o        <= 16'h0000;
			flash_dq_oe_n_o   <= 16'hFFFF;
			flash_sel_n_o     <= 1'b1;
			flash_gate_n_o    <= 1'b1;
			flash_wstrobe_n_o <= 1'b1;
			flash_width_n_o   <= 1'b1;
			flash_clear_n_o   <= 1'b0;
		end
		else
		begin
			rsp_valid_o <= 1'b0;
			reissue_o   <= 1'b0;
			case (state)
				S_IDLE:
				begin
					flash_sel_n_o   <= 1'b1; // standby between cycles
					flash_gate_n_o  <= 1'b1;
					flash_dq_oe_n_o <= 16'hFFFF;
					flash_width_n_o <= ~byte_mode_i;
					selected        <= 1'b0;
					req_ready_o     <= 1'b1;
					if (req_valid_i && req_ready_o)
					begin
						req_ready_o <= 1'b0;
						op          <= req_op_i;
						step        <= 3'h0;
						seq_end     <= 1'b0;
						uaddr       <= req_addr_i;
						udata       <= req_data_i;
						if (req_op_i == `PFBM_OP_HW_RESET)
						begin
							state           <= S_CLRLOW;
							cnt             <= CP_CYC;
							busy_seen       <= ~op_done_flag_n;
							flash_clear_n_o <= 1'b0;
						end
						else
							state <= S_LOOK;
					end
					if (!flash_clear_n_o)
					begin
						// release from power-up reset, then wait to read
						req_ready_o     <= 1'b0;
						flash_clear_n_o <= 1'b1;
						state           <= S_RECOV;
						cnt             <= RH_CYC;
					end
				end
				S_LOOK:
				begin
					if (op == `PFBM_OP_READ)
					begin
						// byte mode: low bit rides on pin 15
						flash_addr_o    <= uaddr[20:1];
						flash_dq_o      <= {uaddr[0], 15'h0000};
						flash_dq_oe_n_o <= byte_mode_i ? 16'h7FFF : 16'hFFFF;
						flash_sel_n_o   <= 1'b0;
						flash_gate_n_o  <= 1'b0;
						cnt             <= selected ? ACC_CYC : SEL_CYC;
						state           <= S_READ;
					end
					else if (op == `PFBM_OP_WRITE)
					begin
						flash_addr_o    <= uaddr[20:1];
						flash_dq_o      <= byte_mode_i ? {uaddr[0], 7'h00, udata[7:0]} : udata;
						flash_dq_oe_n_o <= byte_mode_i ? 16'h7F00 : 16'h0000;
						flash_sel_n_o   <= 1'b0;
						flash_wstrobe_n_o <= 1'b0;
						cnt             <= WP_CYC;
						state           <= S_WLOW;
					end
					else
						state <= S_WHIGH;
				end
				S_WLOW:
				begin
					// command cycle: strobe and select low, gate high
					flash_gate_n_o <= 1'b1;
					if (cnt > 16'h0001)
						cnt <= cnt - 16'h0001;
					else
					begin
						flash_wstrobe_n_o <= 1'b1;
						cnt               <= WH_CYC;
						step              <= step + 3'h1;
						state             <= S_WHIGH;
					end
				end
				S_WHIGH:
				begin
					if (cnt > 16'h0001)
						cnt <= cnt - 16'h0001;
					else if ((op == `PFBM_OP_WRITE) || seq_end)
					begin
						// sequence done; erase or program runs on after deselect
						if (op == `PFBM_OP_BYPASS_ENTER)
							bypass <= 1'b1;
						if (op == `PFBM_OP_WRITE && udata == `PFBM_CMD_RESET)
							bypass <= 1'b0;
						flash_sel_n_o   <= 1'b1;
						flash_dq_oe_n_o <= 16'hFFFF;
						rsp_valid_o     <= 1'b1;
						rsp_data_o      <= 16'h0000;
						state           <= S_IDLE;
					end
					else if (cnt == 16'h0001)
					begin
						// wait one cycle so rom index settles
						cnt <= 16'h0000;
					end
					else
					begin
						// program data width follows width select
						flash_addr_o      <= rom_addr;
						flash_dq_o        <= byte_mode_i ?
							{uaddr[0], 7'h00, rom_data[7:0]} : rom_data;
						flash_dq_oe_n_o   <= byte_mode_i ? 16'h7F00 : 16'h0000;
						// end mark belongs to the cycle issued now, not the next step
						seq_end           <= rom_last;
						flash_sel_n_o     <= 1'b0;
						flash_gate_n_o    <= 1'b1;
						flash_wstrobe_n_o <= 1'b0;
						cnt               <= WP_CYC;
						state             <= S_WLOW;
					end
				end
				S_READ:
				begin
					// array, ident code or status all use read timing
					if (cnt > 16'h0001)
						cnt <= cnt - 16'h0001;
					else
					begin
						rsp_data_o     <= byte_mode_i ? {8'h00, flash_dq_i[7:0]} : flash_dq_i;
						rsp_valid_o    <= 1'b1;
						selected       <= 1'b1;
						flash_gate_n_o <= 1'b1;
						state          <= S_IDLE;
					end
				end
				S_CLRLOW:
				begin
					// hold clear past its minimum pulse
					if (~op_done_flag_n)
						busy_seen <= 1'b1;
					if (cnt > 16'h0001)
						cnt <= cnt - 16'h0001;
					else
					begin
						flash_clear_n_o <= 1'b1;
						bypass          <= 1'b0; // device back in array read
						cnt             <= CRD_CYC;
						state           <= S_CLRWT;
					end
				end
				S_CLRWT:
				begin
					// busy flag low until internal reset done
					if (cnt > 16'h0001 && (!busy_seen || ~op_done_flag_n))
						cnt <= cnt - 16'h0001;
					else
					begin
						reissue_o <= busy_seen;
						cnt       <= RH_CYC;
						state     <= S_RECOV;
					end
				end
				S_RECOV:
				begin
					if (cnt > 16'h0001)
						cnt <= cnt - 16'h0001;
					else
					begin
						rsp_valid_o <= (op == `PFBM_OP_HW_RESET);
						state       <= S_IDLE;
					end
				end
				default:
					state <= S_IDLE;
			endcase
		end
	end
endmodule // pfbm_host

// ==== testbench/pfbm_flash_model.sv ====
// Purpose: behavioural flash device at the far side of the host
// Assumes: pins move on clk_i edges; times counted in clk_i cycles
// Notes:   released data lines toggle every cycle so stale data never matches
`timescale 1ns/1ps

module pfbm_flash_model
#(
	parameter       BUSY_CYC  = 30,
	parameter       READY_CYC = 12,
	parameter [7:0] ID_CODE   = 8'h5A, // arbitrary value
	parameter [7:0] STATUS    = 8'h4C
)
(
	// clock
	input  wire        clk_i,
	// device pins
	input  wire [19:0] addr_i,
	input  wire [15:0] dq_i,
	input  wire        sel_n_i,
	input  wire        gate_n_i,
	input  wire        wstrobe_n_i,
	input  wire        width_n_i,
	input  wire        clear_n_i,
	output reg  [15:0] dq_o,
	output wire        op_done_flag_n
);
	reg [7:0]  m [int];
	int        st = 0;
	int        cnt = 0;
	int        job = 0;
	int        q [$];
	reg        ident = 0;
	reg        bypass = 0;
	reg        jw;
	reg [20:0] ja;
	reg [15:0] jd;
	reg [15:0] v;
	wire [20:0] b = width_n_i ? {addr_i, 1'b0} : {addr_i, dq_i[15]};
	wire        drive = !sel_n_i && !gate_n_i && clear_n_i;

	assign op_done_flag_n = (cnt == 0);
	initial dq_o = 16'h0000;

	function [7:0] rb(input int k);
		rb = m.exists(k) ? m[k] : 8'hFF;
	endfunction

	function int sect(input [19:0] w);
		if (w[19:15] != 5'h1F)
			sect = w[19:15];
		else if (!w[14])
			sect = 31;
		else if (w[13])
			sect = 34;
		else
			sect = 32 + w[12];
	endfunction

	// command decode; writes ignored while clear is low
	always @(posedge wstrobe_n_i)
		if (!sel_n_i && gate_n_i && clear_n_i)
		begin
			if (st == 3 || st == 6)
			begin
				job = (st == 3) ? 1 : (dq_i[7:0] == 8'h30) ? 2 : 3;
				ja = b;
				jd = dq_i;
				jw = width_n_i;
				cnt = BUSY_CYC;
				st = 0;
			end
			else if (dq_i[7:0] == 8'hF0)
			begin
				st = 0;
				ident = 0;
				bypass = 0;
			end
			else
				case (st)
					0: st = (dq_i[7:0] == 8'hAA) ? 1 : (bypass && dq_i[7:0] == 8'hA0) ? 3 : 0;
					1: st = (dq_i[7:0] == 8'h55) ? 2 : 0;
					2:
					begin
						ident = (dq_i[7:0] == 8'h90);
						bypass = bypass || (dq_i[7:0] == 8'h20);
						st = (dq_i[7:0] == 8'hA0) ? 3 : (dq_i[7:0] == 8'h80) ? 4 : 0;
					end
					4: st = (dq_i[7:0] == 8'hAA) ? 5 : 0;
					5: st = (dq_i[7:0] == 8'h55) ? 6 : 0;
					default: st = 0;
				endcase
		end

	// abort cuts the job, busy stays low a little longer
	always @(negedge clear_n_i)
	begin
		if (cnt > 0)
			cnt = READY_CYC;
		job = 0;
		st = 0;
		ident = 0;
		bypass = 0;
	end

	always @(posedge clk_i)
	begin
		v = (cnt > 0 && job != 0) ? {8'h00, STATUS} : ident ? {8'h00, ID_CODE} :
			width_n_i ? {rb(b + 1), rb(b)} : {8'h00, rb(b)};
		if (drive)
			dq_o <= width_n_i ? v : {~dq_o[15:8], v[7:0]};
		else
			dq_o <= ~dq_o;
		if (cnt == 1 && job == 1)
		begin
			m[ja] = jd[7:0];
			if (jw)
				m[ja + 1] = jd[15:8];
		end
		if (cnt == 1 && job == 2)
		begin
			q.delete();
			foreach (m[k])
				if (sect(k >> 1) == sect(ja[20:1]))
					q.push_back(k);
			foreach (q[i])
				m.delete(q[i]);
		end
		if (cnt == 1 && job == 3)
			m.delete();
		if (cnt > 0)
			cnt = cnt - 1;
	end
endmodule // pfbm_flash_model

// ==== testbench/pfbm_host_sva.sv ====
// Purpose: port-level checks of the flash host
// Assumes: one request at a time
// Notes:   bypass state is tracked from the requests taken
`timescale 1ns/1ps
`include "pfbm_map.vh"

module pfbm_host_sva
#(
	parameter CLEAR_READY_CYC = 10
)
(
	// clock and requests
	input wire        clk_i,
	input wire        reset_n_i,
	input wire        req_valid_i,
	input wire [2:0]  req_op_i,
	input wire [15:0] req_data_i,
	input wire        byte_mode_i,
	input wire        req_ready_o,
	input wire        rsp_valid_o,
	// flash pins
	input wire [19:0] flash_addr_o,
	input wire [15:0] flash_dq_oe_n_o,
	input wire        flash_sel_n_o,
	input wire        flash_gate_n_o,
	input wire        flash_wstrobe_n_o,
	input wire        flash_width_n_o,
	input wire        flash_clear_n_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	reg       byp;
	reg [3:0] nwr;
	reg [6:0] nlow;
	reg [2:0] op;
	wire      take = req_valid_i && req_ready_o;

	always @(posedge clk_i or negedge reset_n_i)
		if (!reset_n_i)
		begin
			byp <= 1'b0;
			nwr <= 4'h0;
			nlow <= 7'h3F;
			op <= 3'h0;
		end
		else
		begin
			if (take)
				op <= req_op_i;
			if (take && req_op_i == `PFBM_OP_BYPASS_ENTER)
				byp <= 1'b1;
			if (take && (req_op_i == `PFBM_OP_HW_RESET || req_op_i == `PFBM_OP_WRITE
				&& req_data_i == 16'h00F0))
				byp <= 1'b0;
			nwr <= take ? 4'h0 : nwr + {3'h0, $fell(flash_wstrobe_n_o)};
			nlow <= flash_clear_n_o ? 7'h00 : nlow + {6'h00, nlow != 7'h7F};
		end

	wr_levels_a: assert property (!flash_wstrobe_n_o |-> !flash_sel_n_o && flash_gate_n_o)
		else $error("write strobe low without select low and gate high");
	wr_pulse_a: assert property ($fell(flash_wstrobe_n_o) |->
		!flash_wstrobe_n_o ##1 (!flash_wstrobe_n_o && $stable(flash_addr_o))[*4])
		else $error("write pulse too short");
	rd_levels_a: assert property (!flash_gate_n_o |-> !flash_sel_n_o && flash_wstrobe_n_o)
		else $error("read gate low without select or with strobe");
	gate_nodrive_a: assert property (!flash_gate_n_o |-> &flash_dq_oe_n_o[14:0])
		else $error("host drives data while gate low");
	byte_lanes_a: assert property (!flash_sel_n_o && !flash_width_n_o |->
		!flash_dq_oe_n_o[15] && &flash_dq_oe_n_o[14:8])
		else $error("byte width lane use wrong");
	width_sel_a: assert property (!flash_sel_n_o |-> flash_width_n_o == !byte_mode_i)
		else $error("width select disagrees with byte mode");
	prog_cycles_a: assert property (rsp_valid_o && op == `PFBM_OP_PROGRAM |->
		nwr == (byp ? 4'h2 : 4'h4))
		else $error("program write cycle count wrong");
	read_hold_a: assert property ($fell(flash_gate_n_o) |->
		##1 (!flash_gate_n_o && !flash_sel_n_o && $stable(flash_addr_o))[*8])
		else $error("read ended before access time");
	clear_pulse_a: assert property ($rose(flash_clear_n_o) |-> nlow >= 7'h3F)
		else $error("device reset pulse too short");
	clear_read_a: assert property ($rose(flash_clear_n_o) |-> flash_gate_n_o[*7])
		else $error("read too soon after device reset");

	cover property (rsp_valid_o && op == `PFBM_OP_PROGRAM && byp);
	cover property ($rose(flash_clear_n_o) && op == `PFBM_OP_HW_RESET);
	cover property (take && req_op_i == `PFBM_OP_ERASE_CHIP);
endmodule // pfbm_host_sva

bind pfbm_host pfbm_host_sva #(.CLEAR_READY_CYC(CLEAR_READY_CYC)) pfbm_host_sva_i
(
	.clk_i(clk_i), .reset_n_i(reset_n_i), .req_valid_i(req_valid_i), .req_op_i(req_op_i),
	.req_data_i(req_data_i), .byte_mode_i(byte_mode_i), .req_ready_o(req_ready_o),
	.rsp_valid_o(rsp_valid_o), .flash_addr_o(flash_addr_o), .flash_dq_oe_n_o(flash_dq_oe_n_o),
	.flash_sel_n_o(flash_sel_n_o), .flash_gate_n_o(flash_gate_n_o),
	.flash_wstrobe_n_o(flash_wstrobe_n_o), .flash_width_n_o(flash_width_n_o),
	.flash_clear_n_o(flash_clear_n_o)
);

// ==== testbench/pfbm_host_bench.sv ====
// Purpose: self-checking bench of the flash host against a device model
// Assumes: inputs move 1 ns after the rising edge
// Notes:   random words land in one 64 KB sector, clear of the erase table
`timescale 1ns/1ps
`include "pfbm_map.vh"

module pfbm_host_bench;
	localparam [7:0] ID = 8'h5A; // arbitrary value
	localparam [7:0] ST = 8'h4C;
	reg         clk_i = 0, reset_n_i = 0, req_valid_i = 0, byte_mode_i = 0, seen_re = 0;
	reg  [2:0]  req_op_i = 0;
	reg  [20:0] req_addr_i = 0, a;
	reg  [15:0] req_data_i = 0, lf = 16'hB936, got;
	wire        req_ready_o, rsp_valid_o, reissue_o, op_done_flag_n;
	wire        flash_sel_n_o, flash_gate_n_o, flash_wstrobe_n_o, flash_width_n_o, flash_clear_n_o;
	wire [15:0] rsp_data_o, flash_dq_o, flash_dq_oe_n_o, dev_dq, dq_bus;
	wire [19:0] flash_addr_o;
	int         n_errors = 0, compares = 0, cyc = 0;
	reg  [7:0]  mem [int];
	int         t [4][3] = '{'{21'h1F8000, 21'h1F9FFE, 21'h1FA000}, '{21'h0F1234, 21'h0F0000,
		21'h0EFFFE}, '{21'h1FFFFE, 21'h1FC000, 21'h1FBFFE}, '{21'h1F0000, 21'h1F7FFE, 21'h1F8000}};

	assign dq_bus = (flash_dq_o & ~flash_dq_oe_n_o) | (dev_dq & flash_dq_oe_n_o);
	always #4 clk_i = ~clk_i;

	pfbm_host #(.CLEAR_READY_CYC(10)) pfbm_host_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
		.req_valid_i(req_valid_i), .req_op_i(req_op_i), .req_addr_i(req_addr_i),
		.req_data_i(req_data_i), .byte_mode_i(byte_mode_i), .req_ready_o(req_ready_o),
		.rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .reissue_o(reissue_o),
		.flash_addr_o(flash_addr_o), .flash_dq_o(flash_dq_o), .flash_dq_oe_n_o(flash_dq_oe_n_o),
		.flash_dq_i(dq_bus), .flash_sel_n_o(flash_sel_n_o), .flash_gate_n_o(flash_gate_n_o),
		.flash_wstrobe_n_o(flash_wstrobe_n_o), .flash_width_n_o(flash_width_n_o),
		.flash_clear_n_o(flash_clear_n_o), .op_done_flag_n(op_done_flag_n));
	pfbm_flash_model #(.ID_CODE(ID), .STATUS(ST)) pfbm_flash_model_i (.clk_i(clk_i),
		.addr_i(flash_addr_o), .dq_i(dq_bus), .sel_n_i(flash_sel_n_o), .gate_n_i(flash_gate_n_o),
		.wstrobe_n_i(flash_wstrobe_n_o), .width_n_i(flash_width_n_o),
		.clear_n_i(flash_clear_n_o), .dq_o(dev_dq), .op_done_flag_n(op_done_flag_n));

	function [15:0] rnd;
		lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
		rnd = lf;
	endfunction
	function [7:0] mb(input int k);
		mb = mem.exists(k) ? mem[k] : 8'hFF;
	endfunction
	task check(input string nm, input [15:0] seen, input [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task complete_run;
		$display("mismatches %0d comparisons %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// held until taken, then wait for the one-cycle answer
	task req(input [2:0] op, input [20:0] ad, input [15:0] d);
		req_op_i = op;
		req_addr_i = ad;
		req_data_i = d;
		req_valid_i = 1;
		@(posedge clk_i);
		while (req_ready_o !== 1'b1)
			@(posedge clk_i);
		#1 req_valid_i = 0;
		seen_re = 0;
		while (rsp_valid_o !== 1'b1)
		begin
			@(posedge clk_i);
			#1 seen_re = seen_re | (reissue_o === 1'b1);
		end
		got = rsp_data_o;
	endtask
	task idle;
		while (op_done_flag_n !== 1'b1)
		begin
			@(posedge clk_i);
			#1;
		end
	endtask
	task rdchk(input [20:0] ad);
		req(`PFBM_OP_READ, ad, 16'h0000);
		check("read", got, byte_mode_i ? {8'h00, mb(ad)} : {mb({ad[20:1], 1'b1}), mb({ad[20:1], 1'b0})});
	endtask
	task prog(input [20:0] ad, input [15:0] d);
		req(`PFBM_OP_PROGRAM, ad, d);
		req(`PFBM_OP_READ, ad, 16'h0000);
		check("status", got, {8'h00, ST});
		idle;
		mem[byte_mode_i ? ad : {ad[20:1], 1'b0}] = d[7:0];
		if (!byte_mode_i)
			mem[{ad[20:1], 1'b1}] = d[15:8];
	endtask

	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			n_errors++;
			complete_run;
		end
	end

	initial
	begin
		repeat (6) @(posedge clk_i);
		#1 reset_n_i = 1;
		rdchk(21'h100000 | rnd());
		for (int i = 0; i < 3; i++)
		begin
			a = 21'h100000 | (rnd() & 16'hFFFE);
			prog(a, rnd());
			rdchk(a);
		end
		req(`PFBM_OP_BYPASS_ENTER, 0, 16'h0000);
		for (int i = 0; i < 2; i++)
			prog(21'h100000 | (rnd() & 16'hFFFE), rnd());
		req(`PFBM_OP_WRITE, 0, 16'h00F0);
		rdchk(a);
		// select rises one edge after the read answer; width moves only then
		@(posedge clk_i);
		#1 byte_mode_i = 1;
		a = 21'h100001 | rnd();
		prog(a, rnd());
		rdchk(a);
		rdchk(a ^ 21'h1);
		@(posedge clk_i);
		#1 byte_mode_i = 0;
		foreach (t[i])
		begin
			prog(t[i][1], rnd());
			prog(t[i][2], rnd());
			req(`PFBM_OP_ERASE_SECTOR, t[i][0], 16'h0000);
			idle;
			mem.delete(t[i][1]);
			mem.delete(t[i][1] + 1);
			rdchk(t[i][1]);
			rdchk(t[i][2]);
		end
		req(`PFBM_OP_ERASE_CHIP, 0, 16'h0000);
		idle;
		mem.delete();
		rdchk(a);
		req(`PFBM_OP_IDENT, 0, 16'h0000);
		req(`PFBM_OP_READ, 0, 16'h0000);
		check("ident", got, {8'h00, ID});
		req(`PFBM_OP_HW_RESET, 0, 16'h0000);
		check("idle reissue", seen_re, 1'b0);
		rdchk(21'h1FA000);
		a = 21'h100000 | (rnd() & 16'hFFFE);
		req(`PFBM_OP_PROGRAM, a, rnd());
		req(`PFBM_OP_HW_RESET, 0, 16'h0000);
		check("reissue", seen_re, 1'b1);
		rdchk(a);
		complete_run;
	end
endmodule // pfbm_host_bench
